// *** shared/clkgen_regs.svh ***
/*
 * Constants of the cpu clock source and oscillator monitor: strap codes,
 * multiplication factors (held as twice the factor), monitor and model timing.
 * Assumes inclusion by bare name from the package.
 */
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// strap codes of the clock mode pins
`define STRAP_PRESCALE 3'h1
`define STRAP_DIRECT 3'h3
`define STRAP_X4 3'h7
`define STRAP_X3 3'h6
`define STRAP_X2 3'h5
`define STRAP_X5 3'h4
`define STRAP_X10 3'h2
`define STRAP_X2P5 3'h0

// factor F times two, so that 2.5 stays whole
`define FX2_X4 5'h08
`define FX2_X3 5'h06
`define FX2_X2 5'h04
`define FX2_X5 5'h0a
`define FX2_X10 5'h14
`define FX2_X2P5 5'h05

// monitor overflows after this many free-running pll cycles
`define MON_OVERFLOW 5'h10
// free-running half period of the pll model, in reference cycles
`define FREE_RUN_HALF 12'h002
// starting estimate of the input period, in reference cycles
`define PERIOD_INIT 12'h010

`endif

// *** shared/clkgen_pkg.sv ***
/*
 * Types shared by the clock source block and its pll model.
 * Assumes clkgen_regs.svh is on the include path.
 */
package clkgen_pkg;
  `include "clkgen_regs.svh"

  // clock generation mode chosen at reset
  typedef enum logic [1:0] {
    MODE_PRESCALE = 2'b00,
    MODE_DIRECT = 2'b01,
    MODE_PLL = 2'b10
  } clk_mode_t;

  // controls handed to the pll model
  typedef struct packed {
    logic enable;
    logic locked;
    logic [4:0] factor_x2;
  } pll_ctrl_t;
endpackage : clkgen_pkg

// *** rtl/pll_model.sv ***
/*
 * Digital model of the pll: a phase accumulator toggles the output factor_x2
 * times per measured input period when locked, or at a fixed rate when free.
 * Assumes in_rise_in/in_edge_in are already synchronised edge pulses.
 */
`timescale 1ns/100ps
module pll_model #(
  parameter int PERIOD_W = 12
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // control and input edges
  input wire clkgen_pkg::pll_ctrl_t ctrl_in,
  input wire logic in_rise_in,
  input wire logic in_edge_in,
  // generated clock
  output logic pll_clk_out,
  output logic pll_tick_out
);
  import clkgen_pkg::*;

  logic [PERIOD_W-1:0] acc, next_acc;
  logic [PERIOD_W-1:0] meas, next_meas;
  logic [PERIOD_W-1:0] est, next_est;
  logic [PERIOD_W-1:0] last, next_last;
  logic [3:0] trans, next_trans;
  logic pclk, next_pclk;
  logic tick, next_tick;

  // accumulator, period measurement and gradual resync
  always_comb begin
    logic [PERIOD_W-1:0] step;
    logic [PERIOD_W-1:0] thresh;
    logic [PERIOD_W:0] sum;
    step = '0;
    thresh = '0;
    sum = '0;
    next_acc = acc;
    next_meas = meas;
    next_est = est;
    next_last = last;
    next_trans = trans;
    next_pclk = pclk;
    next_tick = 1'b0;
    step = ctrl_in.locked ? PERIOD_W'(ctrl_in.factor_x2) : PERIOD_W'(1);
    thresh = ctrl_in.locked ? est : `FREE_RUN_HALF;
    if (!ctrl_in.enable) begin
      next_acc = '0;
      next_pclk = 1'b0; // powered off, output parked low
    end else begin
      sum = {1'b0, acc} + {1'b0, step};
      if (sum >= {1'b0, thresh}) begin
        next_acc = PERIOD_W'(sum - {1'b0, thresh});
        next_pclk = !pclk;
        next_tick = !pclk;
      end else begin
        next_acc = sum[PERIOD_W-1:0];
      end
      // input period measured from rising edge to rising edge
      if (in_rise_in) begin
        next_last = meas;
        next_meas = PERIOD_W'(1);
      end else if (meas != '1) begin
        next_meas = meas + PERIOD_W'(1);
      end
      // every F-th input transition pull the estimate halfway, no jump
      if (ctrl_in.locked && in_edge_in) begin
        if ({trans, 1'b0} + 5'h02 >= ctrl_in.factor_x2) begin
          next_trans = '0;
          // round toward the measurement, else a plain halving stalls one short
          next_est = PERIOD_W'(({1'b0, est} + {1'b0, last} + {{PERIOD_W{1'b0}}, last > est}) >> 1);
        end else begin
          next_trans = trans + 4'h1;
        end
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc <= '0;
      meas <= '0;
      est <= `PERIOD_INIT;
      last <= `PERIOD_INIT;
      trans <= '0;
      pclk <= 1'b0;
      tick <= 1'b0;
    end else begin
      acc <= next_acc;
      meas <= next_meas;
      est <= next_est;
      last <= next_last;
      trans <= next_trans;
      pclk <= next_pclk;
      tick <= next_tick;
    end
  end

  assign pll_clk_out = pclk;
  assign pll_tick_out = tick;
endmodule : pll_model

// *** rtl/cpu_clock_source.sv ***
/*
 * CPU clock source with oscillator monitor: strap-selected prescaler, direct
 * drive or pll, and a monitor that falls back to the free-running pll clock.
 * Assumes clock_input_pin_in is asynchronous to ref_clk_in and well below
 * half its rate; the monitor disable level comes from same-clock logic.
 */
// Function
// - strap 001: cpu clock is input halved
// - halved clock phases each one input period
// - strap 011: pll unlocked, cpu clock direct
// - direct mode follows input edge for edge
// - other straps: pll multiplies input by F
// - pll resyncs smoothly every F-th transition
// - monitor enabled at reset, disable bit stops
// - prescale/direct: pll free-runs for monitor or after fail, else off
// - counter counts pll, clears on input transition
// - overflow switches to pll, raises fail flag
// - fallback held until hardware reset only
// - monitor disabled: prescale/direct use input, pll off, unless fail already set
// - strap factor encoding, default 111 times four
`timescale 1ns/100ps
module cpu_clock_source #(
  parameter int PERIOD_W = 12
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // pins and configuration
  input wire logic clock_input_pin_in,
  input wire logic [2:0] clock_mode_strap_pins_in,
  input wire logic osc_monitor_disable_in,
  // generated clock and status
  output logic cpu_clk_out,
  output logic pll_enable_out,
  output clkgen_pkg::clk_mode_t clk_mode_out,
  output logic osc_fail_out,
  output logic osc_fail_interrupt_out
);
  import clkgen_pkg::*;

  // strap decode, used for mode and for factor
  function automatic clk_mode_t mode_of(input logic [2:0] strap);
    if (strap == `STRAP_PRESCALE) begin
      mode_of = MODE_PRESCALE;
    end else if (strap == `STRAP_DIRECT) begin
      mode_of = MODE_DIRECT;
    end else begin
      mode_of = MODE_PLL;
    end
  endfunction : mode_of

  function automatic logic [4:0] factor_of(input logic [2:0] strap);
    unique case (strap)
      `STRAP_X4: factor_of = `FX2_X4;
      `STRAP_X3: factor_of = `FX2_X3;
      `STRAP_X2: factor_of = `FX2_X2;
      `STRAP_X5: factor_of = `FX2_X5;
      `STRAP_X10: factor_of = `FX2_X10;
      `STRAP_X2P5: factor_of = `FX2_X2P5;
      default: factor_of = `FX2_X4; // non-pll codes carry no factor
    endcase
  endfunction : factor_of

  logic sync1, sync2, in_prev;
  logic in_rise, in_edge;
  logic [2:0] strap, next_strap;
  logic [2:0] strap_meta, strap_sync;
  clk_mode_t mode;
  logic [4:0] factor_x2;
  logic [4:0] mon_cnt, next_mon_cnt;
  logic fail, next_fail;
  logic irq, next_irq;
  logic div, next_div;
  logic cpu, next_cpu;
  logic mon_on;
  pll_ctrl_t pll_ctrl;
  logic pll_clk, pll_tick;

  // two-stage synchroniser, then a third stage for edges
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      sync1 <= clock_input_pin_in;
      sync2 <= sync1;
      in_prev <= sync2;
    end
  end
  assign in_rise = sync2 && !in_prev;
  assign in_edge = sync2 != in_prev;

  // strap caught while reset is held, frozen after release; the pins pass two
  // flops first, so they must stand steady for three edges before release
  always_comb begin
    next_strap = rst_in ? strap_sync : strap;
  end
  always_ff @(posedge ref_clk_in) begin
    strap_meta <= clock_mode_strap_pins_in;
    strap_sync <= strap_meta;
    strap <= next_strap;
  end
  assign mode = mode_of(strap);
  assign factor_x2 = factor_of(strap);

  // monitor only guards the prescale and direct modes
  assign mon_on = !osc_monitor_disable_in && mode != MODE_PLL;
  assign pll_ctrl.enable = mode == MODE_PLL || mon_on || fail;
  assign pll_ctrl.locked = mode == MODE_PLL;
  assign pll_ctrl.factor_x2 = factor_x2;

  pll_model #(
    .PERIOD_W(PERIOD_W)
  ) u_pll (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ctrl_in(pll_ctrl),
    .in_rise_in(in_rise),
    .in_edge_in(in_edge),
    .pll_clk_out(pll_clk),
    .pll_tick_out(pll_tick)
  );

  // monitor counter and sticky failure
  always_comb begin
    next_mon_cnt = mon_cnt;
    next_fail = fail;
    next_irq = 1'b0;
    if (!mon_on || in_edge) begin
      next_mon_cnt = '0;
    end else if (pll_tick && mon_cnt != `MON_OVERFLOW) begin
      next_mon_cnt = mon_cnt + 5'h01;
    end
    // fail only ever sets; reset is the sole way back
    if (mon_on && !fail && mon_cnt == `MON_OVERFLOW) begin
      next_fail = 1'b1;
      next_irq = 1'b1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mon_cnt <= '0;
      fail <= 1'b0;
      irq <= 1'b0;
    end else begin
      mon_cnt <= next_mon_cnt;
      fail <= next_fail;
      irq <= next_irq;
    end
  end

  // cpu clock selection
  always_comb begin
    next_div = in_rise ? !div : div;
    if (fail) begin
      next_cpu = pll_clk;
    end else begin
      unique case (mode)
        MODE_PRESCALE: next_cpu = div;
        MODE_DIRECT: next_cpu = sync2;
        MODE_PLL: next_cpu = pll_clk;
        default: next_cpu = sync2; // unused code, fall back to input
      endcase
    end
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      div <= 1'b0;
      cpu <= 1'b0;
    end else begin
      div <= next_div;
      cpu <= next_cpu;
    end
  end

  assign cpu_clk_out = cpu;
  assign pll_enable_out = pll_ctrl.enable;
  assign clk_mode_out = mode;
  assign osc_fail_out = fail;
  assign osc_fail_interrupt_out = irq;
endmodule : cpu_clock_source

// *** test/cpu_clock_source_sva.sv ***
/* port assertions for the cpu clock source.
   assumes one reference clock and its synchronous reset. */
`timescale 1ns/100ps
module cpu_clock_source_sva import clkgen_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // pins
  input wire logic clock_input_pin_in,
  input wire logic osc_monitor_disable_in,
  // outputs
  input wire logic cpu_clk_out,
  input wire logic pll_enable_out,
  input wire clk_mode_t clk_mode_out,
  input wire logic osc_fail_out,
  input wire logic osc_fail_interrupt_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // direct drive with no fault seen; six cycles lets the synchroniser fill
  sequence direct_run;
    clk_mode_out == MODE_DIRECT && !osc_fail_out;
  endsequence
  a_direct_follow: assert property (
    direct_run [*6] |-> cpu_clk_out == $past(clock_input_pin_in, 3)) else $error("cpu clock off the pin");
  a_prescale_edge: assert property (
    $changed(cpu_clk_out) && clk_mode_out == MODE_PRESCALE && !osc_fail_out
    |-> $past(clock_input_pin_in, 4) && !$past(clock_input_pin_in, 5)) else $error("halved clock off rise");
  a_fail_held: assert property (osc_fail_out |=> osc_fail_out) else $error("fail flag dropped");
  a_irq_pulse: assert property (
    osc_fail_interrupt_out |-> osc_fail_out ##1 !osc_fail_interrupt_out) else $error("alarm not a pulse");
  a_irq_raise: assert property (
    $rose(osc_fail_out) |-> ##[0:1] osc_fail_interrupt_out) else $error("alarm missing");
  a_fail_clocks: assert property (
    osc_fail_out [*3] |-> ##[0:2] $changed(cpu_clk_out)) else $error("no fallback clock");
  a_pll_power: assert property (
    clk_mode_out != MODE_PLL && !osc_fail_out |-> pll_enable_out == !osc_monitor_disable_in)
    else $error("pll power wrong");
  a_pll_on: assert property (
    clk_mode_out == MODE_PLL || osc_fail_out |-> pll_enable_out) else $error("pll off");
  a_mode_held: assert property (!$past(rst_in) |-> $stable(clk_mode_out)) else $error("mode moved");
endmodule : cpu_clock_source_sva

bind cpu_clock_source cpu_clock_source_sva chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .clock_input_pin_in(clock_input_pin_in), .osc_monitor_disable_in(osc_monitor_disable_in),
  .cpu_clk_out(cpu_clk_out), .pll_enable_out(pll_enable_out), .clk_mode_out(clk_mode_out),
  .osc_fail_out(osc_fail_out), .osc_fail_interrupt_out(osc_fail_interrupt_out));

// *** test/osc_source_model.sv ***
/* external oscillator driving the clock input pin.
   assumes the bench gives the half period in reference cycles. */
`timescale 1ns/100ps
module osc_source_model (
  // clock and control
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [7:0] half_in,
  // oscillator pin
  output logic pin_out
);
  logic [7:0] cnt;
  logic wrap;
  assign wrap = run_in && cnt == half_in - 8'h01;
  // a stopped crystal simply holds its last level
  always_ff @(posedge ref_clk_in) begin
    cnt <= (rst_in || wrap || !run_in) ? 8'h00 : cnt + 8'h01;
    pin_out <= rst_in ? 1'b0 : pin_out ^ wrap;
  end
endmodule : osc_source_model

// *** test/cpu_clock_source_test.sv ***
/* self-checking bench: strap modes, prescale, direct, monitor fallback.
   assumes the checker and oscillator model are compiled first. */
`timescale 1ns/100ps
module cpu_clock_source_test;
  import clkgen_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] strap = 3'h7;
  logic dis = 1'b0;
  logic run = 1'b1;
  logic [7:0] half = 8'h08;
  logic pin, cpu_clk, pll_en, fail, irq, prev;
  clk_mode_t mode, m;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] tog = 8'h00;
  logic [3:0] irqs = 4'h0;
  logic [15:0] got;
  logic [31:0] note;
  logic [31:0] notes[$];
  event look;
  always #20 ref_clk_in = !ref_clk_in;
  osc_source_model osc (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .run_in(run), .half_in(half), .pin_out(pin));
  cpu_clock_source dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .clock_input_pin_in(pin),
    .clock_mode_strap_pins_in(strap), .osc_monitor_disable_in(dis), .cpu_clk_out(cpu_clk),
    .pll_enable_out(pll_en), .clk_mode_out(mode), .osc_fail_out(fail), .osc_fail_interrupt_out(irq));
  // count clock changes and alarm pulses; also cut a hang short
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    tog <= tog + 8'(cpu_clk !== prev);
    irqs <= irqs + 4'(irq === 1'b1);
    prev <= cpu_clk;
    if (cyc == 4000) begin
      errors++;
      tally_and_finish();
    end
  end
  // oldest note against what the outputs did; a zero mask just clears counts
  always @(look) begin
    got = {tog, irqs, fail, pll_en, mode};
    note = notes.pop_front();
    tog = 8'h00;
    irqs = 4'h0;
    if (note[31:16] != 16'h0) begin
      checked++;
      if ((got & note[31:16]) !== note[15:0]) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, got & note[31:16], note[15:0]);
      end
    end
  end
  task automatic win(input int n, input logic [15:0] mask, input logic [15:0] exp);
    repeat (16) @(posedge ref_clk_in);
    #1 notes.push_back(32'h0);
    -> look;
    repeat (n) @(posedge ref_clk_in);
    #1 notes.push_back({mask, exp & mask});
    -> look;
  endtask : win
  // strap is only meant to count while reset is high
  task automatic restart(input logic [2:0] s);
    @(posedge ref_clk_in);
    rst_in <= 1'b1;
    strap <= s;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    strap <= 3'($urandom);
  endtask : restart
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  // a locked clock makes 2F edges per 16-cycle input period, so 8F in 64 cycles
  function automatic logic [7:0] pll_tog(input int code);
    case (code)
      7: pll_tog = 8'd32; // times 4
      6: pll_tog = 8'd24; // times 3
      5: pll_tog = 8'd16; // times 2
      4: pll_tog = 8'd40; // times 5
      0: pll_tog = 8'd20; // times 2.5
      default: pll_tog = 8'd0; // times 10 needs more than one edge per cycle
    endcase
  endfunction : pll_tog
  // main sequence
  initial begin
    void'($urandom(32'h54e6));
    for (int s = 0; s < 8; s++) begin
      restart(3'(s));
      m = s == 1 ? MODE_PRESCALE : s == 3 ? MODE_DIRECT : MODE_PLL;
      win(64, m == MODE_PLL ? 16'h00ff : 16'hffff, {s == 1 ? 8'd4 : 8'd8, 4'h0, 2'b01, m});
      if (m == MODE_PLL) begin
        repeat (32) @(posedge ref_clk_in); // let the period estimate settle
        win(64, s == 2 ? 16'h00ff : 16'hffff, {pll_tog(s), 4'h0, 2'b01, m});
      end
      $display("strap %0d done", s);
    end
    restart(3'h3);
    @(posedge ref_clk_in) run <= 1'b0;
    win(100, 16'h00ff, {8'd0, 4'h1, 2'b11, MODE_DIRECT});
    @(posedge ref_clk_in) run <= 1'b1;
    win(64, 16'hffff, {8'd32, 4'h0, 2'b11, MODE_DIRECT});
    restart(3'h3);
    win(64, 16'hffff, {8'd8, 4'h0, 2'b01, MODE_DIRECT});
    $display("fallback done");
    restart(3'h1);
    dis <= 1'b1;
    half <= 8'd3 + 8'($urandom % 6);
    @(posedge ref_clk_in);
    win(8 * half, 16'hffff, {8'd4, 4'h0, 2'b00, MODE_PRESCALE});
    @(posedge ref_clk_in) run <= 1'b0;
    win(100, 16'hffff, {8'd0, 4'h0, 2'b00, MODE_PRESCALE});
    @(posedge ref_clk_in) run <= 1'b1;
    dis <= 1'b0;
    win(8 * half, 16'hffff, {8'd4, 4'h0, 2'b01, MODE_PRESCALE});
    $display("prescale done");
    tally_and_finish();
  end
endmodule : cpu_clock_source_test
